// *** dlc_defs.svh ***
// constants for the delay-locked clock generator
//
// Contract
// - the lock flag rises only after the loop has seen a long run of stable source periods.
// - with the startup-wait option set, configuration-complete stays low until lock; the option defaults off.
// - before lock the doubled output is a single-rate clock with a 25/75 duty cycle.
// - with duty correction on (default) the four phase outputs are 50/50, with it off they follow the source.
// - the divided output runs at the zero-phase rate divided by 1.5, 2, 2.5, 3, 4, 5, 8 or 16, default 2.
// - the lock flag stays high through a permitted source stop and after the restart.
// - outputs run on briefly after a stop and stay absent a few cycles after restart while the line fills.
// - a source phase shift shows at the outputs a few cycles later without touching control or lock.
// - reset drops the lock flag within four source cycles and returns the delay taps to zero.
// - after lock the doubled output runs at twice the source rate with 50/50 duty.
// - the 90, 180 and 270 degree outputs lag the zero-phase output by 25, 50 and 75 percent of a period.
`ifndef DLC_DEFS_SVH
`define DLC_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define DLC_CLK_PERIOD_NS   20
`define DLC_DRIFT_NS        1
// longest tolerated drift, rounded down, never below one cycle
`define DLC_DRIFT_CYC       (((`DLC_DRIFT_NS) / (`DLC_CLK_PERIOD_NS)) < 1 ? 1 : ((`DLC_DRIFT_NS) / (`DLC_CLK_PERIOD_NS)))

// ----------------------------------------------------------------
// sizes and defaults
// ----------------------------------------------------------------
`define DLC_PERIOD_W        16
`define DLC_LOCK_CYCLES     3000
`define DLC_DELAY_TAPS      3
`define DLC_MIN_PERIOD      4

`endif

// *** dlc_pkg.sv ***
// types shared by the delay-locked clock generator
`default_nettype none
package dlc_pkg;
   // divide ratio choices for the divided output
   typedef enum logic [2:0] {
      DLC_DIV_1P5,
      DLC_DIV_2,
      DLC_DIV_2P5,
      DLC_DIV_3,
      DLC_DIV_4,
      DLC_DIV_5,
      DLC_DIV_8,
      DLC_DIV_16
   } dlc_div_ratio_t;
endpackage : dlc_pkg
`default_nettype wire

// *** dlc_delay_line.sv ***
// tap delay line carrying the sampled source clock
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defs.svh"
module dlc_delay_line #(
   parameter int DEPTH = `DLC_DELAY_TAPS
) (
   input  wire logic clk,
   input  wire logic sys_rst,
   input  wire logic din,
   output logic      dout
);
   import dlc_pkg::*;

   logic [DEPTH-1:0] taps_r;
   logic [DEPTH-1:0] taps_nxt;
   logic [7:0]       fill_r;
   logic [7:0]       fill_nxt;

   // ----------------------------------------------------------------
   // shift path
   // ----------------------------------------------------------------
   // the last tap is the read register, so dout never sees a gate
   always_comb begin
      taps_nxt = {taps_r[DEPTH-2:0], din};
      fill_nxt = (fill_r < 8'(DEPTH)) ? fill_r + 8'h01 : fill_r;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         taps_r <= '0;
         fill_r <= 8'h00;
      end else begin
         taps_r <= taps_nxt;
         fill_r <= fill_nxt;
      end
   end

   assign dout = taps_r[DEPTH-1];

   // a full line repeats its input exactly DEPTH cycles later
   line_delay_a: assert property (@(posedge clk) disable iff (sys_rst)
      (fill_r >= 8'(DEPTH)) |-> (dout == $past(din, DEPTH)))
      else $error("delay line output does not match delayed input");

endmodule : dlc_delay_line
`default_nettype wire

// *** dlc_clock_gen.sv ***
// delay-locked clock generator: lock, phase, doubled and divided outputs
`timescale 1ns/1ps
`default_nettype none
`include "dlc_defs.svh"
module dlc_clock_gen #(
   parameter int W           = `DLC_PERIOD_W,
   parameter int LOCK_CYCLES = `DLC_LOCK_CYCLES,
   parameter int TAPS        = `DLC_DELAY_TAPS
) (
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic                    source_clock_in,
   input  wire logic                    duty_correct_en,
   input  wire logic                    startup_wait_en,
   input  wire dlc_pkg::dlc_div_ratio_t divide_ratio_setting,
   input  wire logic                    config_seq_done_in,
   output logic                         phase_zero_clock_out,
   output logic                         quarter_phase_clock_out,
   output logic                         half_phase_clock_out,
   output logic                         three_quarter_phase_clock_out,
   output logic                         doubled_clock_out,
   output logic                         divided_clock_out,
   output logic                         lock_out,
   output logic                         config_done_out
);
   import dlc_pkg::*;

   // quarter-period ticks in half an output period of the divider
   function automatic logic [5:0] div_half_ticks(input dlc_div_ratio_t r);
      logic [5:0] n;
      n = 6'h04;
      unique case (r)
         DLC_DIV_1P5: n = 6'h03;
         DLC_DIV_2:   n = 6'h04;
         DLC_DIV_2P5: n = 6'h05;
         DLC_DIV_3:   n = 6'h06;
         DLC_DIV_4:   n = 6'h08;
         DLC_DIV_5:   n = 6'h0a;
         DLC_DIV_8:   n = 6'h10;
         DLC_DIV_16:  n = 6'h20;
      endcase
      return n;
   endfunction : div_half_ticks

   // position of a counter seen from a phase offset, wrapped into one period
   function automatic logic [W-1:0] phase_pos(input logic [W-1:0] c,
                                              input logic [W-1:0] off,
                                              input logic [W-1:0] per);
      logic [W:0] s;
      s = {1'b0, c} + {1'b0, per} - {1'b0, off};
      return (c >= off) ? (c - off) : s[W-1:0];
   endfunction : phase_pos

   // ----------------------------------------------------------------
   // source period measurement and lock
   // ----------------------------------------------------------------
   logic         raw_prev_r, raw_prev_nxt;
   logic [W-1:0] meas_cnt_r, meas_cnt_nxt;
   logic [W-1:0] period_r,   period_nxt;
   logic [W-1:0] high_len_r, high_len_nxt;
   logic [W-1:0] stable_r,   stable_nxt;
   logic         lock_r,     lock_nxt;
   logic         done_r,     done_nxt;
   logic         raw_rise;
   logic         raw_fall;
   logic [W-1:0] diff;
   logic [W-1:0] meas_per;

   assign raw_rise = source_clock_in & ~raw_prev_r;
   assign raw_fall = ~source_clock_in & raw_prev_r;

   // a period within the drift allowance of the last one counts as stable
   always_comb begin
      raw_prev_nxt = source_clock_in;
      meas_cnt_nxt = meas_cnt_r;
      period_nxt   = period_r;
      high_len_nxt = high_len_r;
      stable_nxt   = stable_r;
      lock_nxt     = lock_r;
      diff         = '0;
      meas_per     = '0;
      if (raw_rise) begin
         meas_per     = meas_cnt_r + W'(1);
         meas_cnt_nxt = '0;
         diff = (meas_per >= period_r) ? meas_per - period_r : period_r - meas_per;
         // once locked the count and the period freeze, so a stop or a phase step can
         // neither drop lock nor stretch the first output period after a restart
         if (!lock_r) begin
            period_nxt = meas_per;
            if (diff <= W'(`DLC_DRIFT_CYC) && period_r != '0)
               stable_nxt = stable_r + W'(1);
            else
               stable_nxt = '0;
            if (stable_nxt >= W'(LOCK_CYCLES))
               lock_nxt = 1'b1;
         end
      end else if (meas_cnt_r != '1) begin
         meas_cnt_nxt = meas_cnt_r + W'(1);
      end
      if (raw_fall)
         high_len_nxt = meas_cnt_r + W'(1);
      done_nxt = config_seq_done_in & (~startup_wait_en | lock_r);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         raw_prev_r <= 1'b0;
         meas_cnt_r <= '0;
         period_r   <= '0;
         high_len_r <= '0;
         stable_r   <= '0;
         lock_r     <= 1'b0;
         done_r     <= 1'b0;
      end else begin
         raw_prev_r <= raw_prev_nxt;
         meas_cnt_r <= meas_cnt_nxt;
         period_r   <= period_nxt;
         high_len_r <= high_len_nxt;
         stable_r   <= stable_nxt;
         lock_r     <= lock_nxt;
         done_r     <= done_nxt;
      end
   end

   assign lock_out        = lock_r;
   assign config_done_out = done_r;

   // ----------------------------------------------------------------
   // delay line and output phase generation
   // ----------------------------------------------------------------
   logic         dly_src;
   logic         dly_prev_r, dly_prev_nxt;
   logic         run_r,      run_nxt;
   logic [W-1:0] ph_cnt_r,   ph_cnt_nxt;
   logic [3:0]   phase_r,    phase_nxt;
   logic         dbl_r,      dbl_nxt;
   logic         div_r,      div_nxt;
   logic [5:0]   div_cnt_r,  div_cnt_nxt;
   logic [W-1:0] q_len, h_len, hi_len;
   logic [W-1:0] offs [4];
   logic         tick;
   logic         dly_rise;

   dlc_delay_line #(
      .DEPTH (TAPS)
   ) u_line (
      .clk     (clk),
      .sys_rst (sys_rst),
      .din     (source_clock_in),
      .dout    (dly_src)
   );

   assign dly_rise = dly_src & ~dly_prev_r;
   assign q_len    = period_r >> 2;
   assign h_len    = period_r >> 1;

   // the phase counter restarts on each delayed rising edge, so a source phase
   // step is followed without touching the lock state
   always_comb begin
      dly_prev_nxt = dly_src;
      hi_len       = duty_correct_en ? h_len : high_len_r;
      offs[0]      = '0;
      offs[1]      = q_len;
      offs[2]      = h_len;
      offs[3]      = h_len + q_len;
      run_nxt      = 1'b0;
      ph_cnt_nxt   = '0;
      if (dly_rise) begin
         run_nxt    = (period_r >= W'(`DLC_MIN_PERIOD));
         ph_cnt_nxt = '0;
      end else if (run_r && ph_cnt_r < period_r - W'(1)) begin
         run_nxt    = 1'b1;
         ph_cnt_nxt = ph_cnt_r + W'(1);
      end
      for (int k = 0; k < 4; k++)
         phase_nxt[k] = run_nxt && (phase_pos(ph_cnt_nxt, offs[k], period_r) < hi_len);
      if (lock_r)
         dbl_nxt = run_nxt && (ph_cnt_nxt < q_len ||
                               (ph_cnt_nxt >= h_len && ph_cnt_nxt < offs[3]));
      else
         dbl_nxt = run_nxt && (ph_cnt_nxt < q_len);
      tick = run_nxt && (ph_cnt_nxt == offs[0] || ph_cnt_nxt == offs[1] ||
                         ph_cnt_nxt == offs[2] || ph_cnt_nxt == offs[3]);
      div_nxt     = div_r;
      div_cnt_nxt = div_cnt_r;
      // count quarter periods; a ratio change mid-count cannot stick past the limit
      if (tick) begin
         if (div_cnt_r >= div_half_ticks(divide_ratio_setting) - 6'h01) begin
            div_cnt_nxt = 6'h00;
            div_nxt     = ~div_r;
         end else begin
            div_cnt_nxt = div_cnt_r + 6'h01;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dly_prev_r <= 1'b0;
         run_r      <= 1'b0;
         ph_cnt_r   <= '0;
         phase_r    <= 4'h0;
         dbl_r      <= 1'b0;
         div_r      <= 1'b0;
         div_cnt_r  <= 6'h00;
      end else begin
         dly_prev_r <= dly_prev_nxt;
         run_r      <= run_nxt;
         ph_cnt_r   <= ph_cnt_nxt;
         phase_r    <= phase_nxt;
         dbl_r      <= dbl_nxt;
         div_r      <= div_nxt;
         div_cnt_r  <= div_cnt_nxt;
      end
   end

   // outputs are valid only once lock_out is high; consumers gate on it
   assign phase_zero_clock_out          = phase_r[0];
   assign quarter_phase_clock_out       = phase_r[1];
   assign half_phase_clock_out          = phase_r[2];
   assign three_quarter_phase_clock_out = phase_r[3];
   assign doubled_clock_out             = dbl_r;
   assign divided_clock_out             = div_r;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   lock_clear_a: assert property (@(posedge clk) sys_rst |=> !lock_out)
      else $error("lock still high after reset");

   lock_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      lock_r |=> lock_r)
      else $error("lock dropped without reset");

   lock_count_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(lock_r) |-> (stable_r >= W'(LOCK_CYCLES)))
      else $error("lock rose before the stable count was reached");

   done_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
      (startup_wait_en && !lock_r) |=> !config_done_out)
      else $error("configuration done before lock with startup wait set");

   single_rate_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!lock_r && ph_cnt_nxt >= q_len) |=> !doubled_clock_out)
      else $error("doubled output high past the first quarter before lock");

   zero_phase_a: assert property (@(posedge clk) disable iff (sys_rst)
      (duty_correct_en && run_nxt && ph_cnt_nxt < h_len) |=> phase_zero_clock_out)
      else $error("zero-phase output low in first half with duty correction");

   quarter_lag_a: assert property (@(posedge clk) disable iff (sys_rst)
      (duty_correct_en && run_nxt && ph_cnt_nxt >= q_len && ph_cnt_nxt < offs[3])
      |=> quarter_phase_clock_out)
      else $error("quarter-phase output not high in its lagged half period");

   div_toggle_a: assert property (@(posedge clk) disable iff (sys_rst)
      (tick && div_cnt_r >= div_half_ticks(divide_ratio_setting) - 6'h01)
      |=> (divided_clock_out != $past(divided_clock_out)))
      else $error("divided output missed its toggle");

endmodule : dlc_clock_gen
`default_nettype wire

// *** dlc_src_model.sv ***
// source clock model standing in front of the delay-locked clock generator
`timescale 1ns/1ps
`default_nettype none
module dlc_src_model (
   input  wire logic       clk,
   input  wire logic [7:0] period,
   input  wire logic [7:0] high_len,
   input  wire logic       hold_low,
   output logic            src
);
   // ----------------------------------------------------------------
   // period counter
   // ----------------------------------------------------------------
   logic [7:0] ph_r = 8'h00;
   logic [7:0] ph_nxt;

   // the period is only changed by the bench between runs, never drifted in mid-run
   always_comb begin
      ph_nxt = ph_r + 8'h01;
      // a stop is only taken at the end of a period, deep in the low phase, and a restart
      // begins with a full high phase
      if (ph_r >= period - 8'h01) begin
         ph_nxt = hold_low ? ph_r : 8'h00;
      end
   end

   // registered only, so the source moves just after a clock edge
   always_ff @(posedge clk) begin
      ph_r <= ph_nxt;
   end

   // high for the first high_len cycles of each period
   always_comb begin
      src = (ph_r < high_len);
   end
endmodule : dlc_src_model
`default_nettype wire

// *** testbench.sv ***
// self-checking bench for the delay-locked clock generator
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dlc_pkg::*;
   typedef struct {int kind; int idx; int exp;} dlc_note_t;

   logic           clk     = 1'b0;
   logic           sys_rst = 1'b1;
   logic           dcc     = 1'b1;
   logic           swait   = 1'b1;
   logic           cfg_in  = 1'b1;
   logic           hold    = 1'b0;
   logic [7:0]     per     = 8'h08;
   logic [7:0]     hi      = 8'h04;
   dlc_div_ratio_t ratio   = DLC_DIV_2;
   logic [31:0]    lfsr    = 32'h20ed;
   logic           src;
   wire  [7:0]     outs;
   int             bad_count = 0;
   int             compares  = 0;
   int             pending   = 0;
   int             div_half[8] = '{6, 8, 10, 12, 16, 20, 32, 64};
   dlc_note_t      exp_q[$];

   always #10 clk = ~clk;

   dlc_src_model i_dlc_src_model (.clk(clk), .period(per), .high_len(hi), .hold_low(hold), .src(src));

   // outs: 0..3 phases, 4 doubled, 5 divided, 6 lock, 7 config done
   dlc_clock_gen #(.LOCK_CYCLES(8)) i_dlc_clock_gen (.clk(clk), .sys_rst(sys_rst), .source_clock_in(src),
      .duty_correct_en(dcc), .startup_wait_en(swait), .divide_ratio_setting(ratio),
      .config_seq_done_in(cfg_in), .phase_zero_clock_out(outs[0]), .quarter_phase_clock_out(outs[1]),
      .half_phase_clock_out(outs[2]), .three_quarter_phase_clock_out(outs[3]),
      .doubled_clock_out(outs[4]), .divided_clock_out(outs[5]), .lock_out(outs[6]),
      .config_done_out(outs[7]));

   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next

   // kind 0: high length, kind 1: cycles from phase-zero rise to next rise, kind 2: level
   task automatic expect_val(input int kind, input int idx, input int exp);
      dlc_note_t n;
      n.kind = kind;
      n.idx  = idx;
      n.exp  = exp;
      exp_q.push_back(n);
      pending++;
      wait (pending == 0);
      @(posedge clk);
   endtask : expect_val

   // bounded wait for a level, counting the cycles spent; a stuck output shows as a wrong count
   task automatic wait_lvl(input int i, input logic v, inout int t, inout int c);
      while (outs[i] !== v && t < 300) begin
         @(negedge clk);
         t++;
         c++;
      end
   endtask : wait_lvl

   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   // ----------------------------------------------------------------
   // output watcher
   // ----------------------------------------------------------------
   always begin : watch_outputs
      dlc_note_t n;
      int        got;
      int        t;
      int        d;
      logic      ok;
      wait (pending > 0);
      n = exp_q.pop_front();
      got = 0;
      t = 0;
      d = 0;
      if (n.kind == 2) begin
         @(negedge clk);
         @(negedge clk);
         got = int'(outs[n.idx]);
         ok = (outs[n.idx] === n.exp[0]);
      end else begin
         wait_lvl((n.kind == 1) ? 0 : n.idx, 1'b0, t, d);
         wait_lvl((n.kind == 1) ? 0 : n.idx, 1'b1, t, d);
         if (n.kind == 1) begin
            wait_lvl(n.idx, 1'b0, t, got);
            wait_lvl(n.idx, 1'b1, t, got);
         end else begin
            wait_lvl(n.idx, 1'b0, t, got);
         end
         ok = (got == n.exp) && (t < 300);   // a run-out wait limit counts as a mismatch
      end
      compares++;
      if (!ok) begin
         bad_count++;
         $display("mismatch at %0t: out %0d kind %0d got %0d want %0d", $time, n.idx, n.kind, got, n.exp);
      end
      pending--;
   end

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin : main_seq
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      expect_val(2, 6, 0);
      repeat (30) @(posedge clk);
      expect_val(2, 6, 0);
      expect_val(2, 7, 0);
      expect_val(1, 4, 8);
      expect_val(0, 4, 2);
      // the doubled output is checked before lock above; the phase clocks only once lock is up
      repeat (100) @(posedge clk);
      expect_val(2, 6, 1);
      expect_val(2, 7, 1);
      expect_val(1, 4, 4);
      expect_val(0, 4, 2);
      expect_val(0, 0, 4);
      for (int k = 1; k < 4; k++) expect_val(1, k, 2 * k);
      $display("test lock and phases done");
      // every ratio, settled before the high time is measured
      for (int k = 0; k < 8; k++) begin
         ratio <= dlc_div_ratio_t'(k[2:0]);
         repeat (140) @(posedge clk);
         expect_val(0, 5, div_half[k]);
      end
      $display("test divider done");
      dcc <= 1'b0;
      hi  <= 8'h03;
      repeat (40) @(posedge clk);
      expect_val(0, 0, 3);
      dcc <= 1'b1;
      hi  <= 8'h04;
      $display("test duty correction off done");
      hold <= 1'b1;
      repeat (40) @(posedge clk);
      expect_val(2, 0, 0);
      expect_val(2, 6, 1);
      hold <= 1'b0;
      expect_val(0, 0, 4);
      repeat (40) @(posedge clk);
      expect_val(2, 6, 1);
      expect_val(0, 0, 4);
      $display("test source stop done");
      // mid-run reset, as a cascaded second loop gets after chip reset
      swait   <= 1'b0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      expect_val(2, 6, 0);
      sys_rst <= 1'b0;
      @(posedge clk);
      for (int k = 0; k < 16; k++) begin
         lfsr = lfsr_next(lfsr);
         cfg_in <= lfsr[0];
         expect_val(2, 7, int'(lfsr[0]));
      end
      $display("test reset and config done");
      report_and_stop();
   end

   // the sequence needs about 2000 cycles; allow ten times that
   initial begin : watchdog
      #(20000 * 20);
      bad_count++;
      $display("mismatch at %0t: run did not finish", $time);
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
